// [hw/cbt_pkg.sv]
// Package: register map, field layout, reset values, states for the CAN slice
package cbt_pkg;
	localparam int NOBJ = 15;
	// Byte addresses of the registers (one aligned word each)
	localparam logic [7:0] ADDR_EN_LOW      = 8'h00;
	localparam logic [7:0] ADDR_EN_HIGH     = 8'h04;
	localparam logic [7:0] ADDR_IE_LOW      = 8'h08;
	localparam logic [7:0] ADDR_IE_HIGH     = 8'h0c;
	localparam logic [7:0] ADDR_SIT_LOW     = 8'h10;
	localparam logic [7:0] ADDR_SIT_HIGH    = 8'h14;
	localparam logic [7:0] ADDR_BT_PRESC    = 8'h18;
	localparam logic [7:0] ADDR_BT_JUMPPROP = 8'h1c;
	localparam logic [7:0] ADDR_BT_PHASES   = 8'h20;
	localparam logic [7:0] ADDR_TS_PRESC    = 8'h24;
	localparam logic [7:0] ADDR_TS_LOW      = 8'h28;
	localparam logic [7:0] ADDR_TS_HIGH     = 8'h2c;
	localparam logic [7:0] ADDR_CTRL        = 8'h30;
	localparam logic [7:0] ADDR_STAT        = 8'h34;
	// Field positions
	localparam int BRP_LSB  = 1;
	localparam int SJW_LSB  = 5;
	localparam int PRS_LSB  = 1;
	localparam int PHASE_SEG_TWO_LSB = 4;
	localparam int PHASE_SEG_ONE_LSB = 1;
	localparam int SMP_BIT  = 0;
	localparam int CTRL_ENA_BIT   = 0;
	localparam int CTRL_SWRES_BIT = 1;
	localparam int STAT_OVR_BIT   = 0;
	localparam int STAT_ENFG_BIT  = 1;
	localparam int STAT_BIT_BIT   = 2;
	// Reset values and masks
	localparam logic [7:0] RST_BT_PRESC    = 8'h00;
	localparam logic [7:0] RST_BT_JUMPPROP = 8'h00;
	localparam logic [7:0] RST_BT_PHASES   = 8'h00;
	localparam logic [7:0] RST_TS_PRESC    = 8'h00;
	localparam logic [7:0] MASK_BT_PRESC    = 8'h7e;
	localparam logic [7:0] MASK_BT_JUMPPROP = 8'h6e;
	localparam logic [7:0] MASK_BT_PHASES   = 8'h7f;
	localparam logic [2:0] TS_PRE_DIV  = 3'h7;   // Fixed divide by 8
	localparam logic [1:0] SMP_FIRST   = 2'h2;   // Clocks before sample point
	localparam logic [1:0] SMP_SECOND  = 2'h1;
	// Object config field encodings
	localparam logic [1:0] CFG_DISABLED = 2'h0;
	// Bit timing segments
	typedef enum logic [3:0] {
		SEG_SYNC  = 4'b0001,
		SEG_PROP  = 4'b0010,
		SEG_PHASE_SEG_ONE  = 4'b0100,
		SEG_PHASE_SEG_TWO  = 4'b1000
	} cbt_seg_e;
endpackage : cbt_pkg

// [hw/cbt_sample_vote.sv]
// Three-point majority sampler for the received bus level
module cbt_sample_vote (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic arst_n_i,
	// Control
	input  wire logic triple_i,
	input  wire logic shift_i,
	input  wire logic sample_i,
	input  wire logic rx_i,
	// Result
	output logic      bit_o
);
	logic [1:0] hist_reg;
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			hist_reg <= 2'h3;
		end else if (shift_i) begin
			hist_reg <= {hist_reg[0], rx_i};
		end
	end
	// Majority of samples two and one clocks before, and at, the point
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			bit_o <= 1'b1;
		end else if (sample_i) begin
			if (triple_i) begin
				bit_o <= (hist_reg[1] & hist_reg[0]) | (hist_reg[1] & rx_i)
					| (hist_reg[0] & rx_i);
			end else begin
				bit_o <= rx_i;
			end
		end
	end
endmodule : cbt_sample_vote

// [hw/cbt_top.sv]
// Object flags, bit timing and timestamp timer of the CAN controller
// How it works
// - Enabling an object's config sets in-use bit
// - Tx completion, or rx completion without auto-reply, clears in-use bit
// - Disable, abort or standby clears in-use
// - Fifteen read-only in-use bits, top reserved
// - Fifteen writable interrupt enables, reset zero
// - Fifteen pending interrupt bits, write one to clear
// - Quantum equals prescaler plus one clocks
// - Resync adjusts bit by jump width
// - Propagation segment lasts field plus one
// - Phase two lasts field plus one
// - Phase one lasts field plus one
// - Single or three-point majority sampling
// - Timer tick every eight times prescaler-plus-one
// - Timer ticks only while controller enabled
// - Timer readable as two bytes, reset zero
// - Timer counts full sixteen-bit range
// - Wrap to zero raises overrun flag
module cbt_top
	import cbt_pkg::*;
(
	// Clock and reset
	input  wire logic                clk_i,
	input  wire logic                arst_n_i,
	// APB slave
	input  wire logic                psel_i,
	input  wire logic                penable_i,
	input  wire logic                pwrite_i,
	input  wire logic [7:0]          paddr_i,
	input  wire logic [31:0]         pwdata_i,
	output logic      [31:0]         prdata_o,
	output logic                     pready_o,
	output logic                     pslverr_o,
	// Frame engine events, one bit per object (config field two bits per object), one shared abort
	input  wire logic [NOBJ-1:0]     obj_cfg_write_i,
	input  wire logic [NOBJ*2-1:0]   obj_config_field_i,
	input  wire logic [NOBJ-1:0]     obj_auto_reply_i,
	input  wire logic [NOBJ-1:0]     tx_complete_flag_i,
	input  wire logic [NOBJ-1:0]     rx_complete_flag_i,
	input  wire logic [NOBJ-1:0]     obj_event_i,
	input  wire logic                abort_i,
	// Bus side
	input  wire logic                rx_i,
	input  wire logic                edge_late_i,
	input  wire logic                edge_early_i,
	// Timing outputs
	output logic                     tq_tick_o,
	output logic                     sample_point_o,
	output logic                     rx_bit_o,
	output logic                     ctrl_enabled_o
);
	logic [NOBJ-1:0] obj_in_use_bit_reg;
	logic [NOBJ-1:0] obj_irq_enable_reg;
	logic [NOBJ-1:0] obj_irq_pending_reg;
	logic [7:0]      bt_presc_reg;
	logic [7:0]      bt_jumpprop_reg;
	logic [7:0]      bt_phases_reg;
	logic [7:0]      ts_presc_reg;
	logic [15:0]     timestamp_timer_reg;
	logic            timer_overrun_flag_reg;
	logic            enable_req_reg;
	logic            swres_reg;
	logic            ctrl_enabled_reg;
	logic [5:0]      tq_cnt_reg;
	logic            tq_tick_reg;
	logic [4:0]      seg_cnt_reg;
	cbt_seg_e        seg_reg;
	logic [2:0]      ts_div_reg;
	logic [7:0]      ts_pre_reg;
	logic            sample_point_reg;
	logic [31:0]     prdata_reg;
	logic            pready_reg;
	logic            pslverr_reg;

	function automatic logic [4:0] seg_len(input logic [2:0] f);
		seg_len = {2'h0, f} + 5'h1;
	endfunction : seg_len

	function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
		hit = (a == b);
	endfunction : hit

	logic wr;
	logic rd_ok;
	logic soft_rst;
	assign wr       = psel_i & penable_i & pwrite_i & ~pready_reg;
	assign soft_rst = swres_reg;

	logic [5:0] baud_prescaler;
	logic [1:0] resync_jump_width;
	logic [2:0] propagation_segment;
	logic [2:0] phase_seg_one;
	logic [2:0] phase_seg_two;
	logic       triple_sampling;
	assign baud_prescaler  = bt_presc_reg[BRP_LSB +: 6];
	assign resync_jump_width  = bt_jumpprop_reg[SJW_LSB +: 2];
	assign propagation_segment  = bt_jumpprop_reg[PRS_LSB +: 3];
	assign phase_seg_two = bt_phases_reg[PHASE_SEG_TWO_LSB +: 3];
	assign phase_seg_one = bt_phases_reg[PHASE_SEG_ONE_LSB +: 3];
	assign triple_sampling  = bt_phases_reg[SMP_BIT];

	// Control: enable request and self-clearing soft reset
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			enable_req_reg <= 1'b0;
			swres_reg      <= 1'b0;
		end else begin
			swres_reg <= wr && hit(paddr_i, ADDR_CTRL) && pwdata_i[CTRL_SWRES_BIT];
			if (soft_rst) begin
				enable_req_reg <= 1'b0;
			end else if (wr && hit(paddr_i, ADDR_CTRL)) begin
				enable_req_reg <= pwdata_i[CTRL_ENA_BIT];
			end
		end
	end

	// Enabled state follows the request one clock later
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl_enabled_reg <= 1'b0;
		end else begin
			ctrl_enabled_reg <= enable_req_reg & ~soft_rst;
		end
	end

	// Object in-use bits
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			obj_in_use_bit_reg <= '0;
		end else begin
			for (int i = 0; i < NOBJ; i++) begin
				if (soft_rst || abort_i || !ctrl_enabled_reg) begin
					obj_in_use_bit_reg[i] <= 1'b0;
				end else if (obj_cfg_write_i[i]) begin
					obj_in_use_bit_reg[i] <= (obj_config_field_i[2*i +: 2] != CFG_DISABLED);
				end else if (tx_complete_flag_i[i]
					|| (rx_complete_flag_i[i] && !obj_auto_reply_i[i])) begin
					obj_in_use_bit_reg[i] <= 1'b0;
				end
			end
		end
	end

	// Interrupt enables; reserved top bit is not stored
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			obj_irq_enable_reg <= '0;
		end else if (soft_rst) begin
			obj_irq_enable_reg <= '0;
		end else if (wr && hit(paddr_i, ADDR_IE_LOW)) begin
			obj_irq_enable_reg[7:0] <= pwdata_i[7:0];
		end else if (wr && hit(paddr_i, ADDR_IE_HIGH)) begin
			obj_irq_enable_reg[14:8] <= pwdata_i[6:0];
		end
	end

	// Pending interrupt bits; events gated by enables, write one clears, set wins
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			obj_irq_pending_reg <= '0;
		end else if (soft_rst) begin
			obj_irq_pending_reg <= '0;
		end else begin
			for (int i = 0; i < NOBJ; i++) begin
				if (obj_event_i[i] && obj_irq_enable_reg[i]) begin
					obj_irq_pending_reg[i] <= 1'b1;
				end else if (wr && i < 8 && hit(paddr_i, ADDR_SIT_LOW) && pwdata_i[i % 8]) begin
					obj_irq_pending_reg[i] <= 1'b0;
				end else if (wr && i >= 8 && hit(paddr_i, ADDR_SIT_HIGH)
					&& pwdata_i[i % 8]) begin
					obj_irq_pending_reg[i] <= 1'b0;
				end
			end
		end
	end

	// Bit timing configuration; reserved bits masked
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			bt_presc_reg    <= RST_BT_PRESC;
			bt_jumpprop_reg <= RST_BT_JUMPPROP;
			bt_phases_reg   <= RST_BT_PHASES;
			ts_presc_reg    <= RST_TS_PRESC;
		end else if (wr) begin
			if (hit(paddr_i, ADDR_BT_PRESC)) begin
				bt_presc_reg <= pwdata_i[7:0] & MASK_BT_PRESC;
			end
			if (hit(paddr_i, ADDR_BT_JUMPPROP)) begin
				bt_jumpprop_reg <= pwdata_i[7:0] & MASK_BT_JUMPPROP;
			end
			if (hit(paddr_i, ADDR_BT_PHASES)) begin
				bt_phases_reg <= pwdata_i[7:0] & MASK_BT_PHASES;
			end
			if (hit(paddr_i, ADDR_TS_PRESC)) begin
				ts_presc_reg <= pwdata_i[7:0];
			end
		end
	end

	// Time quantum prescaler
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tq_cnt_reg  <= '0;
			tq_tick_reg <= 1'b0;
		end else if (!ctrl_enabled_reg) begin
			tq_cnt_reg  <= '0;
			tq_tick_reg <= 1'b0;
		end else if (tq_cnt_reg >= baud_prescaler) begin
			tq_cnt_reg  <= '0;
			tq_tick_reg <= 1'b1;
		end else begin
			tq_cnt_reg  <= tq_cnt_reg + 6'h1;
			tq_tick_reg <= 1'b0;
		end
	end

	// Bit segment sequencer with resynchronisation
	logic [4:0] sjw_len;
	logic [4:0] late_adj;
	assign sjw_len  = {3'h0, resync_jump_width} + 5'h1;
	assign late_adj = seg_len(phase_seg_one) + sjw_len;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			seg_reg     <= SEG_SYNC;
			seg_cnt_reg <= '0;
		end else if (!ctrl_enabled_reg) begin
			seg_reg     <= SEG_SYNC;
			seg_cnt_reg <= '0;
		end else if (tq_tick_reg) begin
			unique case (seg_reg)
				SEG_SYNC: begin
					seg_reg     <= SEG_PROP;
					seg_cnt_reg <= seg_len(propagation_segment) - 5'h1;
				end
				SEG_PROP: begin
					if (seg_cnt_reg == 5'h0) begin
						seg_reg <= SEG_PHASE_SEG_ONE;
						// Late edge lengthens phase one
						seg_cnt_reg <= (edge_late_i ? late_adj : seg_len(phase_seg_one)) - 5'h1;
					end else begin
						seg_cnt_reg <= seg_cnt_reg - 5'h1;
					end
				end
				SEG_PHASE_SEG_ONE: begin
					if (seg_cnt_reg == 5'h0) begin
						seg_reg     <= SEG_PHASE_SEG_TWO;
						seg_cnt_reg <= seg_len(phase_seg_two) - 5'h1;
					end else begin
						seg_cnt_reg <= seg_cnt_reg - 5'h1;
					end
				end
				SEG_PHASE_SEG_TWO: begin
					// Early edge shortens phase two by up to the jump width
					if (seg_cnt_reg == 5'h0 || (edge_early_i && seg_cnt_reg <= sjw_len)) begin
						seg_reg     <= SEG_SYNC;
						seg_cnt_reg <= '0;
					end else begin
						seg_cnt_reg <= seg_cnt_reg - 5'h1;
					end
				end
			endcase
		end
	end

	// Sample point at end of phase one
	logic sp_now;
	assign sp_now = tq_tick_reg && seg_reg == SEG_PHASE_SEG_ONE && seg_cnt_reg == 5'h0;
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sample_point_reg <= 1'b0;
		end else begin
			sample_point_reg <= sp_now;
		end
	end

	cbt_sample_vote u_vote (
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.triple_i (triple_sampling),
		.shift_i  (ctrl_enabled_reg),
		.sample_i (sp_now),
		.rx_i     (rx_i),
		.bit_o    (rx_bit_o)
	);

	// Timestamp prescaler: divide by 8, then by prescaler plus one
	logic ts_tick;
	assign ts_tick = ctrl_enabled_reg && ts_div_reg == TS_PRE_DIV
		&& ts_pre_reg >= ts_presc_reg;
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ts_div_reg <= '0;
			ts_pre_reg <= '0;
		end else if (!ctrl_enabled_reg) begin
			ts_div_reg <= '0;
			ts_pre_reg <= '0;
		end else begin
			ts_div_reg <= ts_div_reg + 3'h1;
			if (ts_div_reg == TS_PRE_DIV) begin
				ts_pre_reg <= (ts_pre_reg >= ts_presc_reg) ? 8'h0 : ts_pre_reg + 8'h1;
			end
		end
	end

	// Timestamp counter and overrun flag (set wins over clear)
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			timestamp_timer_reg    <= '0;
			timer_overrun_flag_reg <= 1'b0;
		end else if (soft_rst) begin
			timestamp_timer_reg    <= '0;
			timer_overrun_flag_reg <= 1'b0;
		end else begin
			if (ts_tick) begin
				timestamp_timer_reg <= timestamp_timer_reg + 16'h1;
			end
			if (ts_tick && timestamp_timer_reg == 16'hffff) begin
				timer_overrun_flag_reg <= 1'b1;
			end else if (wr && hit(paddr_i, ADDR_STAT) && pwdata_i[STAT_OVR_BIT]) begin
				timer_overrun_flag_reg <= 1'b0;
			end
		end
	end

	// APB read mux
	logic [31:0] rd_val;
	always_comb begin
		rd_val = 32'h0;
		rd_ok  = 1'b1;
		unique case (paddr_i)
			ADDR_EN_LOW:      rd_val[7:0] = obj_in_use_bit_reg[7:0];
			ADDR_EN_HIGH:     rd_val[6:0] = obj_in_use_bit_reg[14:8];
			ADDR_IE_LOW:      rd_val[7:0] = obj_irq_enable_reg[7:0];
			ADDR_IE_HIGH:     rd_val[6:0] = obj_irq_enable_reg[14:8];
			ADDR_SIT_LOW:     rd_val[7:0] = obj_irq_pending_reg[7:0];
			ADDR_SIT_HIGH:    rd_val[6:0] = obj_irq_pending_reg[14:8];
			ADDR_BT_PRESC:    rd_val[7:0] = bt_presc_reg;
			ADDR_BT_JUMPPROP: rd_val[7:0] = bt_jumpprop_reg;
			ADDR_BT_PHASES:   rd_val[7:0] = bt_phases_reg;
			ADDR_TS_PRESC:    rd_val[7:0] = ts_presc_reg;
			ADDR_TS_LOW:      rd_val[7:0] = timestamp_timer_reg[7:0];
			ADDR_TS_HIGH:     rd_val[7:0] = timestamp_timer_reg[15:8];
			ADDR_CTRL:        rd_val[CTRL_ENA_BIT] = enable_req_reg;
			ADDR_STAT: begin
				rd_val[STAT_OVR_BIT]  = timer_overrun_flag_reg;
				rd_val[STAT_ENFG_BIT] = ctrl_enabled_reg;
				rd_val[STAT_BIT_BIT]  = rx_bit_o;
			end
			default:          rd_ok = 1'b0;
		endcase
	end

	// One wait state: pready rises in the second access cycle
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= '0;
		end else if (psel_i && penable_i && !pready_reg) begin
			pready_reg  <= 1'b1;
			pslverr_reg <= ~rd_ok;
			prdata_reg  <= pwrite_i ? 32'h0 : rd_val;
		end else begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
		end
	end

	assign prdata_o       = prdata_reg;
	assign pready_o       = pready_reg;
	assign pslverr_o      = pslverr_reg;
	assign tq_tick_o      = tq_tick_reg;
	assign sample_point_o = sample_point_reg;
	assign ctrl_enabled_o = ctrl_enabled_reg;
endmodule : cbt_top

// [tb/cbt_sva_sv_chk_sva.sv]
// Checker of the register handshake, quantum ticks and enable timing
module cbt_sva
	import cbt_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        arst_n_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [7:0]  paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic        rx_i,
	input wire logic        tq_tick_o,
	input wire logic        sample_point_o,
	input wire logic        rx_bit_o,
	input wire logic        ctrl_enabled_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	logic       acc;
	logic       wr;
	logic [5:0] brp_reg;
	logic [6:0] gap_reg;
	logic       gap_ok_reg;
	logic       smp_reg;
	assign acc = psel_i && penable_i && !pready_o;
	assign wr  = acc && pwrite_i;
	// Gap check void after any write, mode change or bus edge
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			brp_reg    <= 6'h00;
			gap_reg    <= 7'h00;
			gap_ok_reg <= 1'b0;
			smp_reg    <= 1'b0;
		end else begin
			if (wr && paddr_i == ADDR_BT_PRESC) begin
				brp_reg <= pwdata_i[6:1];
			end
			if (wr && paddr_i == ADDR_BT_PHASES) begin
				smp_reg <= pwdata_i[SMP_BIT];
			end
			gap_reg <= tq_tick_o ? 7'h01 : (gap_reg == 7'h7f ? gap_reg : gap_reg + 7'h01);
			if (wr || $changed(ctrl_enabled_o) || $changed(rx_i)) begin
				gap_ok_reg <= 1'b0;
			end else if (tq_tick_o) begin
				gap_ok_reg <= 1'b1;
			end
		end
	end
	sequence s_ctrl_on;
		wr && paddr_i == ADDR_CTRL && !pwdata_i[CTRL_SWRES_BIT] && pwdata_i[CTRL_ENA_BIT];
	endsequence
	sequence s_rd_high;
		acc && !pwrite_i && (paddr_i == ADDR_EN_HIGH || paddr_i == ADDR_SIT_HIGH
			|| paddr_i == ADDR_IE_HIGH);
	endsequence
	a_ready_next: assert property (acc |=> pready_o) else $error("ready missing");
	a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("ready too long");
	a_err_unmapped: assert property (acc && paddr_i > ADDR_STAT |=> pready_o && pslverr_o)
		else $error("unmapped not refused");
	a_err_mapped: assert property (acc && paddr_i <= ADDR_STAT && paddr_i[1:0] == 2'h0
		|=> !pslverr_o) else $error("mapped refused");
	a_upper_zero: assert property (pready_o |-> prdata_o[31:8] == 24'h000000)
		else $error("upper data not zero");
	a_reserved_top: assert property (s_rd_high |=> !prdata_o[7])
		else $error("reserved bit set");
	a_tick_gap: assert property (tq_tick_o && gap_ok_reg |-> gap_reg == {1'b0, brp_reg} + 7'h01)
		else $error("quantum length wrong");
	a_enable_on: assert property (s_ctrl_on |-> ##[1:3] ctrl_enabled_o)
		else $error("enable not taken");
	// Vote result shows one clock after the sample point
	a_vote_single: assert property (sample_point_o && !$past(smp_reg) |->
		rx_bit_o == $past(rx_i)) else $error("single sample wrong");
	a_vote_triple: assert property (sample_point_o && $past(smp_reg) |->
		rx_bit_o == (($past(rx_i, 3) & $past(rx_i, 2)) | ($past(rx_i, 3) & $past(rx_i))
		| ($past(rx_i, 2) & $past(rx_i)))) else $error("majority vote wrong");
endmodule : cbt_sva

bind cbt_top cbt_sva cbt_sva_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
	.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .rx_i(rx_i),
	.tq_tick_o(tq_tick_o), .sample_point_o(sample_point_o), .rx_bit_o(rx_bit_o),
	.ctrl_enabled_o(ctrl_enabled_o));

// [tb/cbt_bus_node.sv]
// Bus node model: drives the receive line through a transceiver delay
module cbt_bus_node #(
	parameter int DLY = 2
) (
	input  wire logic clk_i,
	input  wire logic arst_n_i,
	input  wire logic level_i,
	output logic      rx_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [DLY-1:0] pipe_reg;
	assign rx_o = pipe_reg[DLY-1];
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pipe_reg <= '1;   // Recessive while idle
		end else begin
			pipe_reg <= {pipe_reg[DLY-2:0], level_i};
		end
	end
endmodule : cbt_bus_node

// [tb/test_can_obj_status_bit_timing_timer.sv]
// Self-checking bench for object flags, bit timing and timestamp timer
module test_can_obj_status_bit_timing_timer
	import cbt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        abort = 1'b0, level = 1'b1, late = 1'b0, early = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic        pready, pslverr, rx, sp;
	logic [14:0] cfg_wr = 15'h0, auto_rep = 15'h0, txc = 15'h0, rxc = 15'h0, obj_ev = 15'h0;
	logic [29:0] cfg_fld = 30'h0;
	int          errors = 0, num_checks = 0;
	cbt_top cbt_top_i (.clk_i(clk), .arst_n_i(arst_n), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .obj_cfg_write_i(cfg_wr),
		.obj_config_field_i(cfg_fld), .obj_auto_reply_i(auto_rep), .tx_complete_flag_i(txc),
		.rx_complete_flag_i(rxc), .obj_event_i(obj_ev), .abort_i(abort), .rx_i(rx),
		.edge_late_i(late), .edge_early_i(early), .tq_tick_o(), .sample_point_o(sp),
		.rx_bit_o(), .ctrl_enabled_o());
	cbt_bus_node #(.DLY(2)) cbt_bus_node_i (.clk_i(clk), .arst_n_i(arst_n), .level_i(level),
		.rx_o(rx));
	always #25 clk = ~clk;
	task automatic give_verdict;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : give_verdict
	task automatic chk(input string what, input logic [31:0] x, input logic [31:0] got);
		num_checks++;
		if (got !== x) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, x, got);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) errors++;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		chk($sformatf("reg %h", a), x, q);
	endtask : rd
	task automatic ev(input int k, input logic [14:0] v);
		case (k)
			0: cfg_wr <= v;
			1: txc <= v;
			2: rxc <= v;
			default: obj_ev <= v;
		endcase
		@(posedge clk);
		{cfg_wr, txc, rxc, obj_ev} <= '0;
		repeat (2) @(posedge clk);
	endtask : ev
	// Clocks between two sample point pulses
	task automatic bit_gap(output int n);
		for (n = 0; n < 600 && sp !== 1'b1; n++) @(posedge clk);
		@(posedge clk);
		for (n = 1; n < 600 && sp !== 1'b1; n++) @(posedge clk);
	endtask : bit_gap
	// Timer advance over 240 clocks
	task automatic span(output logic [31:0] d);
		logic [31:0] a, b;
		logic        e;
		apb(1'b0, ADDR_TS_LOW, 32'h0, a, e);
		repeat (236) @(posedge clk);
		apb(1'b0, ADDR_TS_LOW, 32'h0, b, e);
		d = (b - a) & 32'hff;
	endtask : span
	task automatic t_reset;
		logic [31:0] q;
		logic        e;
		for (int i = 0; i < 12; i++) rd(8'(i * 4), 32'h0);
		apb(1'b0, 8'h38, 32'h0, q, e);
		chk("unmapped err", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, q);
	endtask : t_reset
	task automatic t_regs;
		wr(ADDR_IE_LOW, 32'ha5);
		wr(ADDR_IE_HIGH, 32'h5a);
		rd(ADDR_IE_LOW, 32'ha5);
		rd(ADDR_IE_HIGH, 32'h5a);
		wr(ADDR_EN_LOW, 32'hff);
		rd(ADDR_EN_LOW, 32'h0);
		wr(ADDR_TS_LOW, 32'hff);
		rd(ADDR_TS_LOW, 32'h0);
	endtask : t_regs
	task automatic t_objects;
		wr(ADDR_CTRL, 32'h1);
		cfg_fld <= {15{2'h1}};
		auto_rep <= 15'h0008;
		ev(0, 15'h4009);
		rd(ADDR_EN_LOW, 32'h09);
		rd(ADDR_EN_HIGH, 32'h40);
		ev(2, 15'h0009);
		rd(ADDR_EN_LOW, 32'h08);
		ev(1, 15'h0008);
		rd(ADDR_EN_LOW, 32'h0);
		cfg_fld <= 30'h0;
		ev(0, 15'h4000);
		rd(ADDR_EN_HIGH, 32'h0);
		cfg_fld <= {15{2'h1}};
		ev(0, 15'h0003);
		rd(ADDR_EN_LOW, 32'h03);
		abort <= 1'b1;
		@(posedge clk);
		abort <= 1'b0;
		rd(ADDR_EN_LOW, 32'h0);
		ev(0, 15'h0003);
		wr(ADDR_CTRL, 32'h0);
		rd(ADDR_EN_LOW, 32'h0);
	endtask : t_objects
	task automatic t_pending;
		ev(3, 15'h0003);
		rd(ADDR_SIT_LOW, 32'h01);
		wr(ADDR_SIT_LOW, 32'h01);
		rd(ADDR_SIT_LOW, 32'h0);
		wr(ADDR_CTRL, 32'h2);
		rd(ADDR_IE_LOW, 32'h0);
	endtask : t_pending
	task automatic t_timing;
		int g;
		wr(ADDR_BT_PRESC, 32'h02);
		wr(ADDR_BT_JUMPPROP, 32'h02);
		wr(ADDR_BT_PHASES, 32'h14);
		rd(ADDR_BT_PHASES, 32'h14);
		wr(ADDR_CTRL, 32'h1);
		bit_gap(g);
		chk("bit clocks", 32'h10, 32'(g));
		late <= 1'b1;
		bit_gap(g);
		chk("late bit", 32'h1, {31'h0, g > 16 && g <= 18});
		late <= 1'b0;
		early <= 1'b1;
		bit_gap(g);
		chk("early bit", 32'h1, {31'h0, g >= 14 && g < 16});
		early <= 1'b0;
		wr(ADDR_BT_PHASES, 32'h15);
		level <= 1'b0;
		repeat (2) bit_gap(g);
		rd(ADDR_STAT, 32'h02);
		level <= 1'b1;
		repeat (2) bit_gap(g);
		rd(ADDR_STAT, 32'h06);
	endtask : t_timing
	task automatic t_timer;
		logic [31:0] d;
		wr(ADDR_TS_PRESC, 32'h02);
		span(d);
		chk("ticks running", 32'ha, d);
		wr(ADDR_CTRL, 32'h0);
		span(d);
		chk("ticks standby", 32'h0, d);
	endtask : t_timer
	initial begin
		#(50 * 20000);
		errors++;
		give_verdict();
	end
	initial begin
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		t_reset();
		t_regs();
		t_objects();
		t_pending();
		t_timing();
		t_timer();
		give_verdict();
	end
endmodule : test_can_obj_status_bit_timing_timer
